/* logic/alarm_cond_pkg.sv */
// constants, field layout and carrier types of the alarm output conditioning block
package alarm_cond_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TYPES = 8'h04;
  localparam logic [7:0] OFS_DELAY0 = 8'h08;
  localparam logic [7:0] OFS_HS_CFG = 8'h18;
  localparam logic [7:0] OFS_LBA_TIME = 8'h1c;
  localparam logic [7:0] OFS_LBA_CFG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  localparam int NUM_ALARMS = 4;

  // ==========================================================================
  // field positions
  localparam int CTRL_HS_EN_BIT = 0;
  localparam int CTRL_HS_LATCH_BIT = 1;
  localparam int CTRL_HS_ROUTED_BIT = 2;
  localparam int CTRL_KEY_CANCEL_BIT = 3;
  localparam int CTRL_EVENT_CANCEL_BIT = 4;
  localparam int CTRL_ASSIGN_LSB = 8;
  localparam int OFF_DELAY_LSB = 16;
  localparam int HS_SET_LSB = 16;
  localparam int LBA_BAND_LSB = 16;
  localparam int DELAY_W = 10;
  localparam int CUR_W = 10;
  localparam int LBA_TIME_W = 14;
  localparam int LEVEL_W = 14;
  localparam int TEMP_W = 16;

  // ==========================================================================
  // writable bits per register; everything else reads as zero
  localparam logic [31:0] CTRL_MASK = 32'h0000_0f1f;
  localparam logic [31:0] TYPES_MASK = 32'hffff_ffff;
  localparam logic [31:0] DELAY_MASK = 32'h03ff_03ff;
  localparam logic [31:0] HS_CFG_MASK = 32'h03ff_03ff;
  localparam logic [31:0] LBA_TIME_MASK = 32'h0000_3fff;
  localparam logic [31:0] LBA_CFG_MASK = 32'h3fff_3fff;
  localparam logic [31:0] IRQ_MASK_MASK = 32'h0000_003f;

  // ==========================================================================
  // reset values (currents in 0.1 A, temperatures in 0.1 degC)
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] TYPES_RESET = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
  localparam logic [31:0] HS_CFG_RESET = 32'h01f4_0001;
  localparam logic [31:0] LBA_TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] LBA_CFG_RESET = 32'h001e_0050;
  localparam logic [CUR_W-1:0] HS_CANCEL_SETTING = 10'h1f4;

  // ==========================================================================
  // alarm type codes
  localparam logic [7:0] TYPE_NONE = 8'h00;
  localparam logic [7:0] TYPE_LBA = 8'h0c;
  localparam logic [7:0] TYPE_PV_RATE = 8'h0d;

  // ==========================================================================
  // timing
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_CYCLES_DEFAULT = int'(SECOND_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic loop_burnout_alarm;
    logic heater_short_alarm;
    logic [NUM_ALARMS-1:0] process;
  } alarm_out_s;

  typedef struct packed {
    logic signed [TEMP_W-1:0] setpoint;
    logic signed [TEMP_W-1:0] process_value;
  } loop_meas_s;

  typedef enum logic [1:0] {
    LBA_IDLE = 2'b01,
    LBA_WATCH = 2'b10
  } lba_state_e;
endpackage

/* logic/alarm_output_conditioning.sv */
// alarm output conditioning: on/off delays, heater short alarm, loop burnout, wishbone registers
module alarm_output_conditioning
  import alarm_cond_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // measurements and conditions from the controller
  input wire logic [NUM_ALARMS-1:0] alarm_cond_i,
  input wire logic [CUR_W-1:0] heater_current_i,
  input wire logic heater_off_i,
  input wire loop_meas_s loop_meas_i,
  input wire logic setting_level_i,
  // cancel pins
  input wire logic function_key_i,
  input wire logic event_cancel_i,
  // alarm outputs
  output alarm_out_s alarm_o,
  output logic irq_o
);

  // ==========================================================================
  // registers
  logic [31:0] ctrl;
  logic [31:0] types;
  logic [31:0] delay_cfg [NUM_ALARMS];
  logic [31:0] hs_cfg;
  logic [31:0] lba_time;
  logic [31:0] lba_cfg;
  logic [31:0] irq_mask;
  logic [5:0] irq_status;
  logic [31:0] next_rdata;
  logic [31:0] wmask;
  logic bus_req;
  logic bus_wr;
  logic [1:0] delay_idx;
  logic delay_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr = bus_req & we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign delay_hit = (adr_i[7:2] >= OFS_DELAY0[7:2]) && (adr_i[7:2] < OFS_HS_CFG[7:2]);
  assign delay_idx = 2'(adr_i[7:2] - OFS_DELAY0[7:2]);

  // one-cycle answer; ack drops in the cycle after it is given
  // the registered ack masks the held strobe, so one request is never taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req) begin
        dat_o <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (delay_hit) begin
      next_rdata = delay_cfg[delay_idx];
    end else begin
      case (adr_i[7:2])
        OFS_CTRL[7:2]: next_rdata = ctrl;
        OFS_TYPES[7:2]: next_rdata = types;
        OFS_HS_CFG[7:2]: next_rdata = hs_cfg;
        OFS_LBA_TIME[7:2]: next_rdata = lba_time;
        OFS_LBA_CFG[7:2]: next_rdata = lba_cfg;
        OFS_STATUS[7:2]: next_rdata = {26'h0000000, alarm_o};
        OFS_IRQ_STATUS[7:2]: next_rdata = {26'h0000000, irq_status};
        OFS_IRQ_MASK[7:2]: next_rdata = irq_mask;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      types <= TYPES_RESET;
      hs_cfg <= HS_CFG_RESET;
      lba_time <= LBA_TIME_RESET;
      lba_cfg <= LBA_CFG_RESET;
      irq_mask <= 32'h0000_0000;
      for (int i = 0; i < NUM_ALARMS; i++) begin
        delay_cfg[i] <= DELAY_RESET;
      end
    end else if (bus_wr) begin
      if (delay_hit) begin
        delay_cfg[delay_idx] <= merge(delay_cfg[delay_idx], dat_i, wmask) & DELAY_MASK;
      end
      case (adr_i[7:2])
        OFS_CTRL[7:2]: ctrl <= merge(ctrl, dat_i, wmask) & CTRL_MASK;
        OFS_TYPES[7:2]: types <= merge(types, dat_i, wmask) & TYPES_MASK;
        OFS_HS_CFG[7:2]: hs_cfg <= merge(hs_cfg, dat_i, wmask) & HS_CFG_MASK;
        OFS_LBA_TIME[7:2]: lba_time <= merge(lba_time, dat_i, wmask) & LBA_TIME_MASK;
        OFS_LBA_CFG[7:2]: lba_cfg <= merge(lba_cfg, dat_i, wmask) & LBA_CFG_MASK;
        OFS_IRQ_MASK[7:2]: irq_mask <= merge(irq_mask, dat_i, wmask) & IRQ_MASK_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // one-second time base
  // the first tick lands TICK_CYCLES cycles after reset, so the first second after reset is a full one
  logic [31:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // cancel pins: two flip-flops, then edge detect on the settled copy
  logic [1:0] key_sync;
  logic [1:0] event_sync;
  logic key_prev;
  logic event_prev;
  logic latch_cancel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_sync <= 2'b00;
      event_sync <= 2'b00;
      key_prev <= 1'b0;
      event_prev <= 1'b0;
    end else begin
      key_sync <= {key_sync[0], function_key_i};
      event_sync <= {event_sync[0], event_cancel_i};
      key_prev <= key_sync[1];
      event_prev <= event_sync[1];
    end
  end

  assign latch_cancel = (ctrl[CTRL_KEY_CANCEL_BIT] & key_sync[1] & ~key_prev)
    | (ctrl[CTRL_EVENT_CANCEL_BIT] & event_sync[1] & ~event_prev);

  // ==========================================================================
  // loop burnout
  // the reference is re-taken each interval, so the flag reflects the latest interval only
  logic lba_mode;
  logic lba_on;
  logic lba_flag;
  lba_state_e lba_state;
  logic [LBA_TIME_W-1:0] lba_timer;
  logic [16:0] ref_dev;
  logic signed [16:0] diff;
  logic [16:0] dev;
  logic [16:0] lba_level;
  logic [16:0] lba_band;

  assign lba_mode = ctrl[CTRL_ASSIGN_LSB] && (types[7:0] == TYPE_LBA);
  assign lba_on = lba_mode && (lba_time[LBA_TIME_W-1:0] != 14'h0000);
  assign diff = 17'(loop_meas_i.setpoint) - 17'(loop_meas_i.process_value);
  assign dev = diff[16] ? 17'(-diff) : 17'(diff);
  assign lba_level = {3'b000, lba_cfg[LEVEL_W-1:0]};
  assign lba_band = {3'b000, lba_cfg[LBA_BAND_LSB +: LEVEL_W]};

  always_ff @(posedge clk_i) begin
    if (rst_i || !lba_on) begin
      lba_state <= LBA_IDLE;
      lba_timer <= 14'h0000;
      ref_dev <= 17'h00000;
      lba_flag <= 1'b0;
    end else begin
      case (lba_state)
        LBA_IDLE: begin
          lba_flag <= 1'b0;
          lba_timer <= 14'h0000;
          if (dev > lba_level) begin
            lba_state <= LBA_WATCH;
            ref_dev <= dev;
          end
        end
        LBA_WATCH: begin
          if (dev <= lba_level) begin
            lba_state <= LBA_IDLE;
            lba_flag <= 1'b0;
          end else if (tick) begin
            if (lba_timer + 14'h0001 >= lba_time[LBA_TIME_W-1:0]) begin
              // reduced by more than the band clears the flag, otherwise burnout
              lba_flag <= ({1'b0, ref_dev} <= {1'b0, dev} + {1'b0, lba_band});
              ref_dev <= dev;
              lba_timer <= 14'h0000;
            end else begin
              lba_timer <= lba_timer + 14'h0001;
            end
          end
        end
        default: lba_state <= LBA_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // heater short alarm
  // a detect wins over a cancel in the same cycle: the short is still present
  logic hs_q;
  logic hs_active;
  logic hs_detect;
  logic hs_release;
  logic [CUR_W-1:0] hs_set;

  assign hs_active = ctrl[CTRL_HS_EN_BIT] & ctrl[CTRL_HS_ROUTED_BIT];
  assign hs_set = hs_cfg[HS_SET_LSB +: CUR_W];
  assign hs_detect = heater_off_i && (heater_current_i >= hs_set);
  assign hs_release = ({1'b0, heater_current_i} + {1'b0, hs_cfg[CUR_W-1:0]}) < {1'b0, hs_set};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_q <= 1'b0;
    end else if (!hs_active || setting_level_i) begin
      hs_q <= 1'b0;
    end else if (ctrl[CTRL_HS_LATCH_BIT]) begin
      if (hs_set == HS_CANCEL_SETTING) begin
        hs_q <= 1'b0;
      end else if (hs_detect) begin
        hs_q <= 1'b1;
      end else if (latch_cancel) begin
        hs_q <= 1'b0;
      end
    end else if (hs_detect) begin
      hs_q <= 1'b1;
    end else if (hs_release) begin
      hs_q <= 1'b0;
    end
  end

  // ==========================================================================
  // process alarm on/off delays
  // delays count whole ticks, so a change shows between delay-1 and delay seconds after it
  logic [NUM_ALARMS-1:0] proc_out;

  for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
    logic out_q;
    logic [DELAY_W-1:0] cnt;
    logic [7:0] type_code;
    logic assigned;
    logic apply;
    logic [DELAY_W-1:0] wait_s;

    assign type_code = types[8*g +: 8];
    assign assigned = ctrl[CTRL_ASSIGN_LSB + g];
    assign apply = assigned && (type_code != TYPE_NONE) && (type_code != TYPE_LBA)
      && (type_code != TYPE_PV_RATE);
    assign wait_s = alarm_cond_i[g] ? delay_cfg[g][DELAY_W-1:0] : delay_cfg[g][OFF_DELAY_LSB +: DELAY_W];
    assign proc_out[g] = out_q;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_q <= 1'b0;
        cnt <= 10'h000;
      end else if (!assigned || type_code == TYPE_NONE) begin
        out_q <= 1'b0;
        cnt <= 10'h000;
      end else if (g == 0 && lba_mode) begin
        out_q <= lba_flag;
        cnt <= 10'h000;
      end else if (!apply || alarm_cond_i[g] == out_q) begin
        out_q <= alarm_cond_i[g];
        cnt <= 10'h000;
      end else if (wait_s == 10'h000) begin
        out_q <= alarm_cond_i[g];
        cnt <= 10'h000;
      end else if (tick) begin
        if (cnt + 10'h001 >= wait_s) begin
          out_q <= alarm_cond_i[g];
          cnt <= 10'h000;
        end else begin
          cnt <= cnt + 10'h001;
        end
      end
    end
  end

  // ==========================================================================
  // outputs and interrupt
  alarm_out_s next_alarm;
  logic [5:0] rise;
  logic [5:0] irq_clear;

  assign next_alarm = '{loop_burnout_alarm: lba_flag, heater_short_alarm: hs_q, process: proc_out};
  assign rise = next_alarm & ~alarm_o;
  assign irq_clear = (bus_wr && adr_i[7:2] == OFS_IRQ_STATUS[7:2]) ? (dat_i[5:0] & wmask[5:0]) : 6'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o <= '0;
      irq_status <= 6'h00;
      irq_o <= 1'b0;
    end else begin
      alarm_o <= next_alarm;
      // a new rising edge wins over a clear in the same cycle
      irq_status <= (irq_status & ~irq_clear) | rise;
      irq_o <= |(irq_status & irq_mask[5:0]);
    end
  end

endmodule

/* verification/alarm_cond_checker.sv */
// port-level assertions for the alarm output conditioning block
module alarm_cond_checker
  import alarm_cond_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // measurements and pins
  input wire logic [NUM_ALARMS-1:0] alarm_cond_i,
  input wire logic [CUR_W-1:0] heater_current_i,
  input wire logic heater_off_i,
  input wire loop_meas_s loop_meas_i,
  input wire logic setting_level_i,
  input wire logic function_key_i,
  input wire logic event_cancel_i,
  // outputs
  input wire alarm_out_s alarm_o,
  input wire logic irq_o
);
  // ==========================================================================
  // register shadows: full-word writes only, byte lanes are not modelled
  logic [31:0] ctrl;
  logic [31:0] types;
  wire logic take = cyc_i && stb_i && we_i && !ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      types <= TYPES_RESET;
    end else if (take && adr_i[7:2] == OFS_CTRL[7:2]) begin
      ctrl <= dat_i & CTRL_MASK;
    end else if (take && adr_i[7:2] == OFS_TYPES[7:2]) begin
      types <= dat_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // assertions
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack in the cycle after a request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  reset_clear_a: assert property ($past(rst_i) |-> alarm_o == '0 && !irq_o && !ack_o)
    else $error("outputs not clear after reset");
  unassigned_off_a: assert property ((!ctrl[CTRL_ASSIGN_LSB+3])[*3] |-> !alarm_o.process[3])
    else $error("unassigned alarm output active");
  pass_through_a: assert property ((ctrl[CTRL_ASSIGN_LSB+2] && types[23:16] == TYPE_PV_RATE)[*3]
    |-> alarm_o.process[2] == $past(alarm_cond_i[2], 2))
    else $error("type 13 alarm not passed straight through");
  hs_level_a: assert property (setting_level_i[*3] |-> !alarm_o.heater_short_alarm)
    else $error("heater short active in a setting level");
  hs_enable_a: assert property ((!ctrl[CTRL_HS_EN_BIT])[*3] |-> !alarm_o.heater_short_alarm)
    else $error("heater short active while disabled");
  hs_routed_a: assert property ((!ctrl[CTRL_HS_ROUTED_BIT])[*3] |-> !alarm_o.heater_short_alarm)
    else $error("heater short active with no output routed");
  lba_gate_a: assert property ((!ctrl[CTRL_ASSIGN_LSB] || types[7:0] != TYPE_LBA)[*3]
    |-> !alarm_o.loop_burnout_alarm)
    else $error("loop burnout active without alarm 1 type 12");

  cover property ($rose(alarm_o.process[1]));
  cover property ($rose(alarm_o.heater_short_alarm));
  cover property ($rose(alarm_o.loop_burnout_alarm));
endmodule

bind alarm_output_conditioning alarm_cond_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .alarm_cond_i(alarm_cond_i),
  .heater_current_i(heater_current_i), .heater_off_i(heater_off_i), .loop_meas_i(loop_meas_i),
  .setting_level_i(setting_level_i), .function_key_i(function_key_i),
  .event_cancel_i(event_cancel_i), .alarm_o(alarm_o), .irq_o(irq_o)
);

/* verification/alarm_sensor_model.sv */
// far-side model: comparators, current measurement and cancel pins
module alarm_sensor_model
  import alarm_cond_pkg::*;
(
  // clock
  input wire logic clk_i,
  // commanded by the bench
  input wire logic [NUM_ALARMS-1:0] cond_i,
  input wire logic [CUR_W-1:0] cur_i,
  input wire logic hoff_i,
  input wire loop_meas_s meas_i,
  input wire logic key_i,
  input wire logic evt_i,
  // toward the block
  output logic [NUM_ALARMS-1:0] cond_o,
  output logic [CUR_W-1:0] cur_o,
  output logic hoff_o,
  output loop_meas_s meas_o,
  output logic key_o,
  output logic evt_o
);
  // one conversion cycle of latency, as a real sampling front end would add
  always_ff @(posedge clk_i) begin
    cond_o <= cond_i;
    cur_o <= cur_i;
    hoff_o <= hoff_i;
    meas_o <= meas_i;
    key_o <= key_i;
    evt_o <= evt_i;
  end
endmodule

/* verification/testbench.sv */
// self-checking bench for the alarm output conditioning block
module testbench
  import alarm_cond_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] r; logic [31:0] w; logic [31:0] b;} row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, irq;
  logic [31:0] rd_dat;
  logic [3:0] cond = 4'h0, m_cond;
  logic [9:0] cur = 10'h000, m_cur;
  loop_meas_s meas = '0, m_meas;
  logic key = 1'b0, evt = 1'b0, hoff = 1'b0, lvl = 1'b0, m_key, m_evt, m_hoff;
  alarm_out_s al;
  int err_total = 0;
  int checks_done = 0;
  row_s rows [10] = '{
    '{OFS_TYPES, TYPES_RESET, 32'h020d_010c, 32'h020d_010c},
    '{8'h0c, DELAY_RESET, 32'hfc02_fc03, 32'h0002_0003},
    '{8'h10, DELAY_RESET, 32'h0005_0005, 32'h0005_0005},
    '{OFS_HS_CFG, HS_CFG_RESET, 32'h0064_0005, 32'h0064_0005},
    '{OFS_LBA_TIME, LBA_TIME_RESET, 32'hffff_c000, 32'h0000_0000},
    '{OFS_LBA_CFG, LBA_CFG_RESET, 32'hc01e_c050, 32'h001e_0050},
    '{OFS_IRQ_MASK, 32'h0000_0000, 32'hffff_ffe0, 32'h0000_0020},
    '{OFS_STATUS, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000},
    '{8'h40, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_CTRL, CTRL_RESET, 32'h1234_0f05, 32'h0000_0f05}};

  always #5 clk_i = ~clk_i;

  alarm_sensor_model partner (.clk_i(clk_i), .cond_i(cond), .cur_i(cur), .hoff_i(hoff), .meas_i(meas),
    .key_i(key), .evt_i(evt), .cond_o(m_cond), .cur_o(m_cur), .hoff_o(m_hoff), .meas_o(m_meas),
    .key_o(m_key), .evt_o(m_evt));
  // a short tick keeps second-scale delays to tens of cycles
  alarm_output_conditioning #(.TICK_CYCLES(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rd_dat), .ack_o(ack),
    .alarm_cond_i(m_cond), .heater_current_i(m_cur), .heater_off_i(m_hoff), .loop_meas_i(m_meas),
    .setting_level_i(lvl), .function_key_i(m_key), .event_cancel_i(m_evt), .alarm_o(al), .irq_o(irq));

  // ==========================================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // entered just after a rising edge; ack and data are taken at the edge that shows ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      print_verdict();
    end
    q = rd_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic waitb(input int b, input logic v, output int c);
    c = 0;
    while (al[b] !== v && c < 400) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= 400) begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic hs(input logic [9:0] c, input logic e);
    cur <= c;
    repeat (8) @(posedge clk_i);
    chk("heater_short", al.heater_short_alarm, e);
  endtask

  task automatic pin(input logic k, input logic e);
    key <= k;
    evt <= !k;
    repeat (4) @(posedge clk_i);
    key <= 1'b0;
    evt <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("latch_cancel", al.heater_short_alarm, e);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] q;
    int c;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("alarms_after_reset", al, 32'h0000_0000);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0, q);
      chk("reset_value", q, rows[i].r);
      wr(rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0, q);
      chk("read_back", q, rows[i].b);
    end
    cond <= 4'hf;
    repeat (4) @(posedge clk_i);
    chk("zero_on_delay", al.process, 32'h0000_000c);
    waitb(1, 1'b1, c);
    chk("on_delay", c >= 16 && c <= 32, 32'h1);
    cond <= 4'h0;
    repeat (4) @(posedge clk_i);
    chk("zero_off_delay", al.process, 32'h0000_0002);
    waitb(1, 1'b0, c);
    chk("off_delay", c >= 6 && c <= 22, 32'h1);
    hoff <= 1'b1;
    hs(10'h064, 1'b1);
    hs(10'h060, 1'b1);
    hs(10'h05e, 1'b0);
    wr(OFS_CTRL, 32'h0000_0f07);
    hs(10'h064, 1'b1);
    hs(10'h000, 1'b1);
    pin(1'b1, 1'b1);
    wr(OFS_CTRL, 32'h0000_0f0f);
    pin(1'b1, 1'b0);
    hs(10'h064, 1'b1);
    wr(OFS_CTRL, 32'h0000_0f17);
    hs(10'h000, 1'b1);
    pin(1'b0, 1'b0);
    hs(10'h064, 1'b1);
    lvl <= 1'b1;
    hs(10'h000, 1'b0);
    lvl <= 1'b0;
    hs(10'h064, 1'b1);
    hs(10'h000, 1'b1);
    wr(OFS_HS_CFG, 32'h01f4_0005);
    hs(10'h000, 1'b0);
    wr(OFS_CTRL, 32'h0000_0f05);
    hs(10'h258, 1'b1);
    wr(OFS_CTRL, 32'h0000_0f06);
    hs(10'h258, 1'b0);
    wr(OFS_CTRL, 32'h0000_0f03);
    hs(10'h258, 1'b0);
    hoff <= 1'b0;
    chk("irq_masked", irq, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h0000_003f);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, q);
    chk("irq_status_clear", q, 32'h0);
    wr(OFS_LBA_TIME, 32'h0000_0002);
    meas <= {16'h03e8, 16'h0384};
    waitb(5, 1'b1, c);
    chk("burnout_time", c >= 8 && c <= 70, 32'h1);
    // alarm 1 follows the burnout flag through one more flop, so it shows a cycle later
    repeat (3) @(posedge clk_i);
    chk("burnout_on_alarm1", al.process[0], 32'h1);
    chk("irq_raised", irq, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h0000_0020);
    repeat (2) @(posedge clk_i);
    chk("irq_cleared", irq, 32'h0);
    meas <= {16'h03e8, 16'h03b6};
    repeat (6) @(posedge clk_i);
    chk("below_level", al.loop_burnout_alarm, 32'h0);
    wr(OFS_LBA_TIME, 32'h0000_0000);
    meas <= {16'h03e8, 16'h0384};
    repeat (60) @(posedge clk_i);
    chk("burnout_disabled", al.loop_burnout_alarm, 32'h0);
    // mid-run reset with alarms standing: all must return to the reset state
    cond <= 4'hf;
    repeat (4) @(posedge clk_i);
    chk("alarms_before_reset", al.process, 32'h0000_000c);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("alarms_mid_reset", al, 32'h0000_0000);
    chk("irq_mid_reset", irq, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, q);
    chk("ctrl_mid_reset", q, CTRL_RESET);
    print_verdict();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
endmodule
